//--- tb/sub_xor_swap_sleep_exec_test.sv
// Purpose: self-checking bench for the subtract/xor/swap/sleep execution block
// Assumes: register bus answers after waitrequest drops, one instruction pulse per exec call
// Notes: flags are observed through the status register, results through acc and fileWr
`timescale 1ns/1ns
module sub_xor_swap_sleep_exec_test;
  import sxs_pkg::*;
  typedef struct packed {
    op_t op;
    logic d;
    logic [7:0] lit;
    logic [7:0] fd;
    logic [7:0] acc;
    logic [7:0] fwd;
    logic [4:0] fl;
  } step_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  instr_t instr = '0;
  logic [DATA_W-1:0] fileData = 8'h00;
  logic wdtTick = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  fwrite_t fileWr;
  logic instrReady;
  logic oscRun;
  logic [31:0] rd;
  int bad_count = 0;
  int cmp_count = 0;
  // fl is {timeout, powerdown, zero, half carry, carry}; acc starts at 03
  step_t steps [12] = '{
    '{OP_REG_SUB, 1'b1, 8'h00, 8'h05, 8'h03, 8'h02, 5'h1b},
    '{OP_LIT_SUB, 1'b0, 8'h03, 8'h00, 8'h00, 8'h00, 5'h1f},
    '{OP_REG_XOR, 1'b0, 8'h00, 8'h01, 8'h01, 8'h00, 5'h1b},
    '{OP_LIT_SUB, 1'b0, 8'h10, 8'h00, 8'h0f, 8'h00, 5'h19},
    '{OP_LIT_XOR, 1'b0, 8'h0f, 8'h00, 8'h00, 8'h00, 5'h1d},
    '{OP_REG_XOR, 1'b1, 8'h00, 8'ha5, 8'h00, 8'ha5, 5'h19},
    '{OP_LIT_XOR, 1'b0, 8'ha5, 8'h00, 8'ha5, 8'h00, 5'h19},
    '{OP_REG_SUB, 1'b0, 8'h00, 8'h00, 8'h5b, 8'h00, 5'h18},
    '{OP_SWAP, 1'b1, 8'h00, 8'h3c, 8'h5b, 8'hc3, 5'h18},
    '{OP_SWAP, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 5'h18},
    '{OP_REG_XOR, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 5'h1c},
    '{OP_REG_SUB, 1'b1, 8'h00, 8'h80, 8'h00, 8'h80, 5'h1b}
  };

  sub_xor_swap_sleep_exec i_sub_xor_swap_sleep_exec (.sys_clk(sys_clk), .rst(rst), .instrValid(instrValid),
    .instr(instr), .fileData(fileData), .wdtTick(wdtTick), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .fileWr(fileWr),
    .instrReady(instrReady), .oscRun(oscRun));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // waitrequest and readdata are taken at the rising edge, before the slave updates
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      bad_count++;
      $display("mismatch at %0t: bus wait ran out", $time);
      summarize();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // operand is scrambled after the pulse so a late sample cannot match
  task automatic exec(input op_t op, input logic d, input logic [7:0] lit, input logic [7:0] fd);
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instr <= '{op: op, dest: d, addr: 7'h7f, lit: lit};
    fileData <= fd;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    fileData <= ~fd;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, OFS_ACC, 32'h0);
    chk(rd, 32'h0, "acc after reset");
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h18, "status after reset");
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b1, OFS_ACC, 32'h3);
    $display("test reset and bus done");
    foreach (steps[i]) begin
      exec(steps[i].op, steps[i].d, steps[i].lit, steps[i].fd);
      @(posedge sys_clk);
      chk({31'h0, fileWr.en}, {31'h0, steps[i].d}, "file write strobe");
      if (steps[i].d) begin
        chk({fileWr.addr, fileWr.data}, {7'h7f, steps[i].fwd}, "file write value");
      end
      @(posedge sys_clk);
      chk({31'h0, fileWr.en}, 32'h0, "file write strobe width");
      bus(1'b0, OFS_ACC, 32'h0);
      chk(rd, {24'h0, steps[i].acc}, "acc result");
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {27'h0, steps[i].fl}, "status flags");
    end
    $display("test arithmetic done");
    @(posedge sys_clk);
    wdtTick <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wdtTick <= 1'b0;
    bus(1'b0, OFS_WDT, 32'h0);
    chk(rd, 32'h0300, "watchdog before sleep");
    exec(OP_SLEEP, 1'b0, 8'h00, 8'h00);
    @(posedge sys_clk);
    chk({30'h0, instrReady, oscRun}, 32'h0, "halted in sleep");
    bus(1'b0, OFS_WDT, 32'h0);
    chk(rd, 32'h0, "watchdog cleared");
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h13, "sleep status");
    bus(1'b0, OFS_WAKE, 32'h0);
    chk(rd, 32'h1, "asleep bit");
    exec(OP_LIT_XOR, 1'b0, 8'hff, 8'h00);
    bus(1'b0, OFS_ACC, 32'h0);
    chk(rd, 32'h0, "no execution in sleep");
    bus(1'b1, OFS_WAKE, 32'h1);
    @(posedge sys_clk);
    chk({30'h0, instrReady, oscRun}, 32'h3, "running after wake");
    $display("test sleep done");
    summarize();
  end
endmodule

//--- verilog/sub_xor_swap_sleep_exec.sv
// Purpose: executes power-down, subtract, xor and nibble-swap instructions
// Assumes: a decoded instruction with a one-cycle valid, file operand valid in the same cycle
// Notes: accumulator, flags and watchdog live here and are visible over Avalon-MM
//
// Function
// - sleep clears watchdog, prescaler, sets timeout, clears powerdown
// - after sleep, halt execution and stop oscillator
// - literal minus accumulator into accumulator, C DC Z
// - accumulator xor literal into accumulator, Z only
// - register minus accumulator, C DC Z
// - destination bit selects accumulator or register
// - accumulator xor register, routed by destination, Z only
// - swap register nibbles, flags unchanged
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module sub_xor_swap_sleep_exec
  import sxs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire instr_t instr,
  input wire logic [DATA_W-1:0] fileData,
  input wire logic wdtTick,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output fwrite_t fileWr,
  output logic instrReady,
  output logic oscRun
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_t state_q;
  logic [DATA_W-1:0] acc_q;
  logic cFlag_q, dcFlag_q, zFlag_q;
  logic timeout_flag_q, powerdown_flag_q;
  logic [WDT_W-1:0] watchdog_counter_q;
  logic [PRE_W-1:0] prescaler_q;
  logic busDone_q;

  logic exec;
  assign exec = instrValid && state_q == ST_RUN;
  assign instrReady = state_q == ST_RUN;
  assign oscRun = state_q == ST_RUN;

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] minuend, result;
  logic [DATA_W:0] diff;
  logic [4:0] lowDiff;
  logic isSub, isXor, isReg, setsZ;

  always_comb begin
    isSub = instr.op == OP_LIT_SUB || instr.op == OP_REG_SUB;
    isXor = instr.op == OP_LIT_XOR || instr.op == OP_REG_XOR;
    isReg = instr.op == OP_REG_SUB || instr.op == OP_REG_XOR || instr.op == OP_SWAP;
    setsZ = isSub || isXor;
    minuend = (instr.op == OP_LIT_SUB || instr.op == OP_LIT_XOR) ? instr.lit : fileData;
    // two's complement: a + ~w + 1, carry out is the no-borrow flag
    diff = {1'b0, minuend} + {1'b0, ~acc_q} + 9'h001;
    lowDiff = {1'b0, minuend[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
    result = diff[DATA_W-1:0];
    if (isXor) begin
      result = minuend ^ acc_q;
    end else if (instr.op == OP_SWAP) begin
      result = {fileData[3:0], fileData[7:4]};
    end
  end

  logic toAcc;
  assign toAcc = exec && (instr.op == OP_LIT_SUB || instr.op == OP_LIT_XOR || (isReg && !instr.dest));

  // ---------------------------------------------------------------
  // accumulator and register write-back
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q <= ACC_RST;
    end else if (toAcc) begin
      acc_q <= result;
    end else if (write && busDone_q && address == OFS_ACC) begin
      acc_q <= writedata[DATA_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fileWr <= '0;
    end else begin
      fileWr.en <= exec && isReg && instr.dest;
      fileWr.addr <= instr.addr;
      fileWr.data <= result;
    end
  end

  // ---------------------------------------------------------------
  // arithmetic flags
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cFlag_q <= 1'b0;
      dcFlag_q <= 1'b0;
      zFlag_q <= 1'b0;
    end else if (exec && setsZ) begin
      zFlag_q <= result == 8'h00;
      if (isSub) begin
        cFlag_q <= diff[DATA_W];
        dcFlag_q <= lowDiff[4];
      end
    end else if (write && busDone_q && address == OFS_STATUS) begin
      cFlag_q <= writedata[BIT_C];
      dcFlag_q <= writedata[BIT_DC];
      zFlag_q <= writedata[BIT_Z];
    end
  end

  // ---------------------------------------------------------------
  // power-down, watchdog and sleep state
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timeout_flag_q <= 1'b1;
      powerdown_flag_q <= 1'b1;
    end else if (exec && instr.op == OP_SLEEP) begin
      timeout_flag_q <= 1'b1;
      powerdown_flag_q <= 1'b0;
    end
  end

  // the watchdog keeps counting in sleep; it has its own oscillator
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      watchdog_counter_q <= WDT_CLR;
      prescaler_q <= PRE_CLR;
    end else if (exec && instr.op == OP_SLEEP) begin
      watchdog_counter_q <= WDT_CLR;
      prescaler_q <= PRE_CLR;
    end else if (wdtTick) begin
      prescaler_q <= prescaler_q + 8'h01;
      if (prescaler_q == 8'hff) begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
    end
  end

  // only software (wake register) leaves sleep; wake sources live elsewhere
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (exec && instr.op == OP_SLEEP) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // writes land on the edge where waitrequest is low, as the master expects
          if (write && busDone_q && address == OFS_WAKE && writedata[0]) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // avalon-mm slave: one wait cycle, answer on the second edge
  // ---------------------------------------------------------------
  assign waitrequest = (read || write) && !busDone_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busDone_q <= 1'b0;
    end else begin
      busDone_q <= (read || write) && !busDone_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !busDone_q) begin
      if (address == OFS_ACC) begin
        readdata <= {24'h000000, acc_q};
      end else if (address == OFS_STATUS) begin
        readdata <= {27'h0, timeout_flag_q, powerdown_flag_q, zFlag_q, dcFlag_q, cFlag_q};
      end else if (address == OFS_WDT) begin
        readdata <= {16'h0000, prescaler_q, watchdog_counter_q};
      end else if (address == OFS_WAKE) begin
        readdata <= {31'h0, state_q == ST_SLEEP};
      end else begin
        readdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sleep_clears_wdt_a: assert property (exec && instr.op == OP_SLEEP |=>
    watchdog_counter_q == 8'h00 && prescaler_q == 8'h00 && timeout_flag_q && !powerdown_flag_q)
    else $error("sleep did not clear watchdog or set flags");
  sleep_halts_a: assert property (exec && instr.op == OP_SLEEP |=> !instrReady && !oscRun)
    else $error("execution not halted after sleep");
  lit_sub_a: assert property (exec && instr.op == OP_LIT_SUB |=>
    acc_q == $past(instr.lit) - $past(acc_q))
    else $error("literal subtract wrong");
  lit_xor_a: assert property (exec && instr.op == OP_LIT_XOR |=>
    acc_q == ($past(instr.lit) ^ $past(acc_q)) && $stable(cFlag_q) && $stable(dcFlag_q))
    else $error("literal xor wrong");
  reg_sub_a: assert property (exec && instr.op == OP_REG_SUB && instr.dest |=>
    fileWr.en && fileWr.data == $past(fileData) - $past(acc_q))
    else $error("register subtract wrong");
  dest_route_a: assert property (exec && isReg && !instr.dest |=> !fileWr.en)
    else $error("destination zero wrote the register");
  reg_xor_a: assert property (exec && instr.op == OP_REG_XOR && !instr.dest |=>
    acc_q == ($past(fileData) ^ $past(acc_q)) && $stable(cFlag_q))
    else $error("register xor wrong");
  swap_flags_a: assert property (exec && instr.op == OP_SWAP |=>
    $stable({cFlag_q, dcFlag_q, zFlag_q}) && (!$past(instr.dest) || fileWr.data == {$past(fileData[3:0]), $past(fileData[7:4])}))
    else $error("swap wrong or flags touched");
  sub_carry_a: assert property (exec && isSub |=>
    cFlag_q == ($past(minuend) >= $past(acc_q)) && zFlag_q == ($past(minuend) == $past(acc_q)))
    else $error("subtract flags wrong");

  sleep_c: cover property (exec && instr.op == OP_SLEEP);
  borrow_c: cover property (exec && isSub && minuend < acc_q);
  swap_c: cover property (exec && instr.op == OP_SWAP && instr.dest);
  bus_c: cover property (read && !waitrequest);
  wake_c: cover property (state_q == ST_SLEEP && write && !waitrequest && address == OFS_WAKE);

  // ---------------------------------------------------------------
  // routing and flag checks
  // ---------------------------------------------------------------
  // a destination-zero register op must land in the accumulator
  reg_route_acc_a: assert property (exec && isReg && !instr.dest |=>
    acc_q == $past(result))
    else $error("register op with destination zero missed the accumulator");

  // literal ops never touch the file register
  lit_no_file_a: assert property (exec && !isReg |=> !fileWr.en)
    else $error("literal op wrote the register");

  xor_flags_a: assert property (exec && isXor |=>
    $stable(cFlag_q) && $stable(dcFlag_q) && zFlag_q == ($past(result) == 8'h00))
    else $error("xor flags wrong");

  // half carry is the no-borrow of the low nibble
  dc_borrow_a: assert property (exec && isSub |=>
    dcFlag_q == ($past(minuend[3:0]) >= $past(acc_q[3:0])))
    else $error("half carry wrong");

  // ---------------------------------------------------------------
  // sleep, watchdog and bus checks
  // ---------------------------------------------------------------
  // nothing executes while asleep, so no write-back can follow
  sleep_no_write_a: assert property (state_q == ST_SLEEP |=> !fileWr.en)
    else $error("register written while asleep");

  wake_run_a: assert property (state_q == ST_SLEEP && write && !waitrequest &&
    address == OFS_WAKE && writedata[0] |=> instrReady && oscRun)
    else $error("wake write did not resume execution");

  // prescaler wrap carries into the watchdog counter
  wdt_wrap_a: assert property (wdtTick && !(exec && instr.op == OP_SLEEP) && prescaler_q == 8'hff |=>
    prescaler_q == 8'h00 && watchdog_counter_q == $past(watchdog_counter_q) + 8'h01)
    else $error("watchdog prescaler wrap wrong");

  // the slave always answers after exactly one wait cycle
  bus_one_wait_a: assert property ((read || write) && !busDone_q |=> !waitrequest)
    else $error("bus answer not after one wait cycle");

  acc_bus_write_a: assert property (write && !waitrequest && address == OFS_ACC && !toAcc |=>
    acc_q == $past(writedata[DATA_W-1:0]))
    else $error("accumulator bus write lost");

  status_read_a: assert property (read && waitrequest && address == OFS_STATUS |=>
    readdata[4:0] == {$past(timeout_flag_q), $past(powerdown_flag_q), $past(zFlag_q), $past(dcFlag_q),
    $past(cFlag_q)})
    else $error("status read layout wrong");
endmodule

//--- verilog/sxs_pkg.sv
// Purpose: shared constants and types for the subtract/xor/swap/sleep execution block
// Assumes: 8-bit data, 7-bit file address, 32-bit Avalon-MM register bus
// Notes: byte offsets are word aligned
package sxs_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_ACC = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_WDT = 4'h8;
  localparam logic [3:0] OFS_WAKE = 4'hc;

  localparam int BIT_C = 0;
  localparam int BIT_DC = 1;
  localparam int BIT_Z = 2;
  localparam int BIT_PD = 3;
  localparam int BIT_TO = 4;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [WDT_W-1:0] WDT_CLR = 8'h00;
  localparam logic [PRE_W-1:0] PRE_CLR = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SLEEP = 3'h1,
    OP_LIT_SUB = 3'h2,
    OP_LIT_XOR = 3'h3,
    OP_REG_SUB = 3'h4,
    OP_REG_XOR = 3'h5,
    OP_SWAP = 3'h6
  } op_t;

  typedef struct packed {
    op_t op;
    logic dest;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] lit;
  } instr_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fwrite_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01
  } state_t;
endpackage
